// [rc_timer_cfg.svh]
// timing constants and reset values for the rc discharge voltage timer
`ifndef RC_TIMER_CFG_SVH
`define RC_TIMER_CFG_SVH
`define CNT_W 16
`define HALF_W 8
`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define CHG_W 24
`endif

// [rc_timer_pkg.sv]
// types for the rc discharge voltage timer
`default_nettype none
package rc_timer_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MEAS,
      ST_CHARGE,
      ST_REF,
      ST_DONE
   } phase_e;
endpackage
`default_nettype wire

// [rc_discharge_voltage_timer.sv]
// sequencer for the single-slope rc discharge voltage measurement
`timescale 1ns/10ps
`default_nettype none
`include "rc_timer_cfg.svh"

// How it works
// (RL1) idle phase keeps the capacitor pin high impedance so the capacitor settles
// (RL2) input measurement drives pin low, clears and starts counter same cycle
// (RL3) comparator reaching threshold stops the counter without software
// (RL4) input discharge count latched and held for reading
// (RL5) pin driven to supply for programmed charge interval, 5 to 7 tau
// (RL6) reference measurement drives pin low and restarts counter same cycle
// (RL7) reference count latched separately from input count
// (RL8) counts are whole core clock cycles
// (RL9) stop uses fixed-threshold comparator input, not the hysteresis input
// (RL10) conversion runs idle, input discharge, supply charge, reference discharge
// (RL11) controller must not start faster than worst-case conversion period
// (RL12) power-on bit selects comparator function and powers the comparator
// (RL13) counter is two cascaded 8-bit halves forming 16 bits
// (RL14) counter saturating at all ones stops, holds, and raises overflow; code raises none if the threshold is met in that same cycle
// (RL15) done flag on reference latch; clearing it returns pin to idle; code already releases the pin at the latch
module rc_discharge_voltage_timer
   import rc_timer_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // control
   input wire logic start_in,
   input wire logic comparator_power_on_in,
   input wire logic [`CHG_W-1:0] charge_cycles_in,
   input wire logic done_clear_in,
   // comparator, high while capacitor above threshold
   input wire logic threshold_comparator_input_in,
   // capacitor pin and comparator enable
   output logic cap_drive_pin_out,
   output logic cap_drive_pin_oe_out,
   output logic comparator_enable_out,
   // results
   output logic [`CNT_W-1:0] meas_count_out,
   output logic [`CNT_W-1:0] ref_count_out,
   output logic overflow_out,
   output logic done_out,
   output logic busy_out
);
   // ****************************************
   // reset release
   // ****************************************
   // two-edge release so every register leaves reset on one clean edge
   logic rst_meta;
   logic rst_sync_n;
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   phase_e phase, next_phase;
   logic [`HALF_W-1:0] cnt_lo, next_cnt_lo;
   logic [`HALF_W-1:0] cnt_hi, next_cnt_hi;
   logic [`CHG_W-1:0] chg, next_chg;
   logic [`CNT_W-1:0] meas_count, next_meas_count;
   logic [`CNT_W-1:0] ref_count, next_ref_count;
   logic overflow, next_overflow;
   logic done, next_done;
   logic pin_val, next_pin_val;
   logic pin_oe, next_pin_oe;
   logic cmp_en, next_cmp_en;
   logic stop;
   logic sat;

   // comparator gated by power bit so an unpowered comparator never stops timing
   assign stop = comparator_power_on_in && !threshold_comparator_input_in; // see (RL9)
   // saturate rather than wrap, so a missing threshold shows as all ones
   assign sat = ({cnt_hi, cnt_lo} == `CNT_MAX);

   // ****************************************
   // cascaded counter halves
   // ****************************************
   logic [`HALF_W-1:0] inc_lo;
   logic [`HALF_W-1:0] inc_hi;
   always_comb begin
      // low half carries into high half, one count per clock
      inc_lo = cnt_lo + 8'h01; // see (RL8)
      inc_hi = cnt_hi;
      if (cnt_lo == 8'hFF) begin
         inc_hi = cnt_hi + 8'h01; // see (RL13)
      end
   end

   always_comb begin
      next_phase = phase;
      next_cnt_lo = cnt_lo;
      next_cnt_hi = cnt_hi;
      next_chg = chg;
      next_meas_count = meas_count;
      next_ref_count = ref_count;
      next_overflow = overflow;
      next_done = done;
      // drive defaults to low and released, so any unlisted path floats the pin
      next_pin_val = 1'b0;
      next_pin_oe = 1'b0; // see (RL1)
      next_cmp_en = comparator_power_on_in; // see (RL12)
      unique case (phase)
         ST_IDLE: begin
            // a start with the comparator unpowered is dropped; only saturation at all ones could stop it
            if (start_in && comparator_power_on_in) begin
               next_phase = ST_MEAS;
               next_pin_oe = 1'b1; // see (RL2)
               next_cnt_lo = '0;
               next_cnt_hi = '0;
               next_overflow = 1'b0;
            end
         end
         ST_MEAS, ST_REF: begin
            next_pin_oe = 1'b1;
            if (stop || sat) begin // see (RL3)
               if (sat && !stop) begin
                  next_overflow = 1'b1; // see (RL14)
               end
               if (phase == ST_MEAS) begin
                  next_meas_count = {cnt_hi, cnt_lo}; // see (RL4)
                  next_phase = ST_CHARGE; // see (RL10)
                  next_pin_val = 1'b1; // see (RL5)
                  next_chg = charge_cycles_in;
               end else begin
                  next_ref_count = {cnt_hi, cnt_lo}; // see (RL7)
                  next_done = 1'b1; // see (RL15)
                  next_phase = ST_DONE;
                  // pin released with the latch so the next idle settle starts at once
                  next_pin_oe = 1'b0;
               end
            end else begin
               next_cnt_lo = inc_lo; // see (RL8)
               next_cnt_hi = inc_hi; // see (RL13)
            end
         end
         ST_CHARGE: begin
            next_pin_oe = 1'b1;
            next_pin_val = 1'b1; // see (RL5)
            // a zero length acts as one, so the pin is always driven high first
            if (chg <= 24'h000001) begin
               next_phase = ST_REF; // see (RL6)
               next_pin_val = 1'b0;
               next_cnt_lo = '0;
               next_cnt_hi = '0;
            end else begin
               next_chg = chg - 24'h000001;
            end
         end
         ST_DONE: begin
            // clear waits for software; a clear in the set cycle cannot occur here
            if (done_clear_in) begin
               next_done = 1'b0;
               next_phase = ST_IDLE; // see (RL15)
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         phase <= ST_IDLE;
         cnt_lo <= '0;
         cnt_hi <= '0;
         chg <= '0;
         meas_count <= `CNT_RESET;
         ref_count <= `CNT_RESET;
         overflow <= 1'b0;
         done <= 1'b0;
         pin_val <= 1'b0;
         pin_oe <= 1'b0;
         cmp_en <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt_lo <= next_cnt_lo;
         cnt_hi <= next_cnt_hi;
         chg <= next_chg;
         meas_count <= next_meas_count;
         ref_count <= next_ref_count;
         overflow <= next_overflow;
         done <= next_done;
         pin_val <= next_pin_val;
         pin_oe <= next_pin_oe;
         cmp_en <= next_cmp_en;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic busy, next_busy;
   // taken from the next phase so busy rises on the edge the pin is first driven
   always_comb begin
      next_busy = (next_phase != ST_IDLE) && (next_phase != ST_DONE);
   end

   always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         busy <= 1'b0;
      end else begin
         busy <= next_busy;
      end
   end

   assign cap_drive_pin_out = pin_val;
   assign cap_drive_pin_oe_out = pin_oe;
   assign comparator_enable_out = cmp_en;
   assign meas_count_out = meas_count;
   assign ref_count_out = ref_count;
   assign overflow_out = overflow;
   assign done_out = done;
   assign busy_out = busy;
endmodule // rc_discharge_voltage_timer
`default_nettype wire

// [rc_timer_assertions.sv]
// checker for the rc discharge voltage timer
`timescale 1ns/10ps
`default_nettype none
module rc_timer_assertions (
   input wire logic core_clk_in, rstn_in, start_in, comparator_power_on_in,
   input wire logic [23:0] charge_cycles_in,
   input wire logic done_clear_in, threshold_comparator_input_in, cap_drive_pin_out,
   input wire logic cap_drive_pin_oe_out, comparator_enable_out, overflow_out, done_out,
   input wire logic busy_out,
   input wire logic [15:0] meas_count_out, ref_count_out);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   a_start_drive: assert property (start_in && comparator_power_on_in && !busy_out &&
      !done_out && !cap_drive_pin_oe_out |=> cap_drive_pin_oe_out && !cap_drive_pin_out
      ##1 busy_out) else $error("start not answered");
   a_refuse_off: assert property (start_in && !comparator_power_on_in && !busy_out
      && !done_out && !cap_drive_pin_oe_out |=> !cap_drive_pin_oe_out) else $error("start taken");
   a_meas_stop: assert property (busy_out && cap_drive_pin_oe_out
      && !cap_drive_pin_out && !threshold_comparator_input_in
      |=> cap_drive_pin_out || done_out) else $error("no stop");
   a_meas_hold: assert property (busy_out && cap_drive_pin_oe_out && cap_drive_pin_out
      |=> $stable(meas_count_out)) else $error("input count moved");
   a_done_hiz: assert property (done_out |-> !cap_drive_pin_oe_out)
      else $error("pin driven at done");
   a_done_cause: assert property ($rose(done_out) |-> overflow_out
      || !$past(threshold_comparator_input_in)) else $error("done without threshold");
   a_ovf_sat: assert property ($rose(overflow_out) |-> meas_count_out == 16'hFFFF
      || ref_count_out == 16'hFFFF) else $error("overflow without all ones");
   a_clear_idle: assert property (done_out && done_clear_in
      |=> !done_out && !busy_out) else $error("clear ignored");
   c_done: cover property ($rose(done_out));
   c_ovf: cover property ($rose(overflow_out));
   c_charge: cover property (busy_out && cap_drive_pin_out);
endmodule // rc_timer_assertions
`default_nettype wire

// [rc_cap_model.sv]
// capacitor and fixed threshold comparator on the far side of the pin
`timescale 1ns/10ps
`default_nettype none
module rc_cap_model (
   input wire logic clk_in, pin_in, oe_in,
   input wire logic [16:0] meas_dly_in, ref_dly_in,
   output logic cmp_out);
   logic [16:0] n;
   logic second;
   wire logic disch = oe_in && !pin_in;
   // released or charged pin keeps the cap above threshold
   always_ff @(posedge clk_in) begin
      n <= disch ? n + 17'h1 : 17'h0;
      if (!disch) second <= oe_in;
   end
   // fixed threshold input only, hysteresis input is too loose
   assign cmp_out = !(disch && n >= (second ? ref_dly_in : meas_dly_in));
endmodule // rc_cap_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the rc discharge voltage timer
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic core_clk_in = 0, rstn_in, start_in, comparator_power_on_in, done_clear_in;
   logic [23:0] charge_cycles_in;
   logic threshold_comparator_input_in, cap_drive_pin_out, cap_drive_pin_oe_out;
   logic comparator_enable_out, overflow_out, done_out, busy_out;
   logic [15:0] meas_count_out, ref_count_out;
   logic [16:0] mdly, rdly;
   logic [32:0] exp_q[$];
   logic [32:0] e;
   int err_count = 0, check_count = 0;
   int chg_seen;
   bit hung = 0;
   always #2.5 core_clk_in = ~core_clk_in;
   rc_discharge_voltage_timer rc_discharge_voltage_timer_inst (.*);
   rc_cap_model rc_cap_model_inst (.clk_in(core_clk_in), .pin_in(cap_drive_pin_out),
      .oe_in(cap_drive_pin_oe_out), .meas_dly_in(mdly), .ref_dly_in(rdly),
      .cmp_out(threshold_comparator_input_in));
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ****
   // one conversion; each count equals the discharge length in clocks
   // ****
   task automatic conv(input logic [16:0] md, input logic [16:0] rd, input logic [23:0] ch);
      int i;
      if (hung) return;
      @(negedge core_clk_in);
      mdly = md;
      rdly = rd;
      charge_cycles_in = ch;
      start_in = 1;
      // a discharge beyond all ones saturates and flags overflow
      exp_q.push_back({md[16] | rd[16], md[16] ? 16'hFFFF : md[15:0],
         rd[16] ? 16'hFFFF : rd[15:0]});
      @(negedge core_clk_in);
      start_in = 0;
      // next start only after done, never faster than one whole conversion
      for (i = 0; i < 80000 && done_out !== 1'b1; i++) @(negedge core_clk_in);
      if (done_out !== 1'b1) begin
         err_count++;
         hung = 1;
      end else begin
         check(33'(chg_seen), ch == 24'h0 ? 33'h1 : {9'h0, ch});
         done_clear_in = 1;
         @(negedge core_clk_in);
         done_clear_in = 0;
      end
   endtask
   always @(posedge done_out) begin
      #1;
      e = exp_q.pop_front();
      check({overflow_out, meas_count_out, ref_count_out}, e);
   end
   // cycles the pin spends driven to the supply, cleared by each start
   always @(posedge core_clk_in) begin
      if (start_in) chg_seen <= 0;
      else if (cap_drive_pin_oe_out && cap_drive_pin_out) chg_seen <= chg_seen + 1;
   end
   initial begin
      void'($urandom(32'hEAA0));
      {rstn_in, start_in, done_clear_in, charge_cycles_in, mdly, rdly} = '0;
      comparator_power_on_in = 1;
      repeat (3) @(negedge core_clk_in);
      rstn_in = 1;
      repeat (4) @(negedge core_clk_in);
      check({27'h0, overflow_out, done_out, busy_out, cap_drive_pin_oe_out, cap_drive_pin_out,
         comparator_enable_out}, 33'h1);
      check({1'b0, meas_count_out, ref_count_out}, 33'h0);
      conv(17'h0, 17'h1, 24'h0);
      for (int k = 0; k < 4; k++) conv(17'($urandom % 300), 17'($urandom % 300),
         24'($urandom % 40));
      conv(17'h1FFFF, 17'h5, 24'h1);
      comparator_power_on_in = 0;
      start_in = 1;
      @(negedge core_clk_in);
      start_in = 0;
      repeat (3) @(negedge core_clk_in);
      check({32'h0, cap_drive_pin_oe_out | busy_out}, 33'h0);
      check({32'h0, comparator_enable_out}, 33'h0);
      check(33'(exp_q.size()), 33'h0);
      report_and_stop();
   end
endmodule // tb
bind rc_discharge_voltage_timer rc_timer_assertions rc_timer_assertions_inst (.*);
`default_nettype wire
